/* File: pkg/seeprm_map.vh */
// constants for the spi eeprom serial-side block
// assumes plain verilog-2005 and inclusion by bare name
`ifndef SEEPRM_MAP_VH
`define SEEPRM_MAP_VH
// ************************************************************
// opcodes
// ************************************************************
`define SEEPRM_OP_READ        8'h03
`define SEEPRM_OP_STATUS_RD   8'h05
`define SEEPRM_OP_WRITE_ENABLE_CMD        8'h06
`define SEEPRM_OP_WRITE_DISABLE_CMD        8'h04
`define SEEPRM_OP_STATUS_WR   8'h01
`define SEEPRM_OP_WRITE       8'h02
// ************************************************************
// status register layout
// ************************************************************
`define SEEPRM_SR_PPE         7
`define SEEPRM_SR_BPH         3
`define SEEPRM_SR_BPL         2
`define SEEPRM_SR_WLB         1
`define SEEPRM_SR_BUSY        0
`define SEEPRM_SR_BUSY_VAL    8'hff
`define SEEPRM_SR_RESET       4'h0
// ************************************************************
// widths, counts and timing
// ************************************************************
`define SEEPRM_ADDR_BITS      15
`define SEEPRM_ADDR_RX        16
`define SEEPRM_BYTE_BITS      8
`define SEEPRM_BIT_LAST       3'h7
`define SEEPRM_PROG_TIME_NS   5000000
`define SEEPRM_CLK_NS         8
`endif

/* File: rtl/seeprm_fifo.v */
// small valid/ready fifo, one clock domain
// assumes source and sink share sys_clk and the asynchronous reset
`timescale 1ns/100ps
module seeprm_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             sys_clk,
    input  wire             reset,
    input  wire             flush,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // seeprm_fifo

/* File: rtl/seeprm_core.v */
// serial-side logic of an spi eeprom, oversampling the serial pins on sys_clk
// assumes spi mode 0: input sampled on clock rise, output changed on clock fall;
// the array is a local memory; reset models power-on detection
`timescale 1ns/100ps
`include "seeprm_map.vh"
// Functional notes
// RULE1: protect pin low with its enable bit set refuses status writes.
// RULE2: protect pin falling while selected abandons a pending status write.
// RULE3: a status write already programming finishes despite the protect pin.
// RULE4: enable bit clear makes the protect pin irrelevant.
// RULE5: host sends read opcode then 16 address bits, msb first.
// RULE6: addressed byte starts on serial out right after the last address bit.
// RULE7: continued clocking advances the pointer and outputs the next byte.
// RULE8: pointer wraps from the top location to zero, endlessly.
// RULE9: raising select ends a read and stops output.
// RULE10: after the status-read opcode, eight status bits shift out.
// RULE11: status read is accepted any time, even while programming.
// RULE12: status read during programming returns all ones.
// RULE13: host moves the pause input only while the serial clock is low.
// RULE14: host keeps select low throughout a pause.
// RULE15: paused: serial out released, serial in ignored, state kept.
// RULE16: standby above the power trigger, reset below it.
// RULE17: power-up is standby with the write latch cleared.
// RULE18: host lowers select before the first instruction is taken.
// RULE19: a completed array or status write clears the write latch.
// RULE20: programming starts only on select rise after whole data bytes.
// RULE21: array accesses during programming are ignored.
// RULE22: unknown opcodes do nothing and leave serial out released.
// RULE23: opcodes 03 read, 05 status read, 06/04 latch, 01 status write, 02 write.
// RULE24: only the lower fifteen address bits are used.
// RULE25: status bits: 7 enable, 3-2 block protect, 1 write latch, 0 busy.
// RULE26: select high releases serial out and resets the decoder.
module seeprm_core #(
    parameter ADDR_BITS = `SEEPRM_ADDR_BITS,
    parameter PROG_NS   = `SEEPRM_PROG_TIME_NS,
    parameter PROG_CYC  = (PROG_NS + `SEEPRM_CLK_NS - 1) / `SEEPRM_CLK_NS,
    parameter PAGE_BUF  = 4
) (
    input  wire sys_clk,
    input  wire reset,
    input  wire cs_n,
    input  wire sck,
    input  wire si,
    input  wire hold_n,
    input  wire wp_n,
    output reg  so,
    output reg  so_oe,
    output reg  busy,
    output reg  [7:0] status
);
    // ************************************************************
    // states
    // ************************************************************
    localparam [5:0] ST_OPC  = 6'h01;
    localparam [5:0] ST_ADDR = 6'h02;
    localparam [5:0] ST_RDAT = 6'h04;
    localparam [5:0] ST_SRD  = 6'h08;
    localparam [5:0] ST_WDAT = 6'h10;
    localparam [5:0] ST_IDLE = 6'h20;

    localparam DEPTH = 1 << ADDR_BITS;

    // ************************************************************
    // pin synchronisers and edge detection
    // ************************************************************
    reg  [1:0] s_cs;
    reg  [1:0] s_sck;
    reg  [1:0] s_si;
    reg  [1:0] s_hold;
    reg  [1:0] s_wp;
    reg        sck_d;
    reg        cs_d;
    reg        wp_d;
    wire       sel      = ~s_cs[1];
    wire       held     = ~s_hold[1];
    wire       sck_rise = s_sck[1] & ~sck_d & sel & ~held; // see RULE15
    wire       sck_fall = ~s_sck[1] & sck_d & sel & ~held;
    wire       cs_rise  = s_cs[1] & ~cs_d;
    wire       wp_fall  = ~s_wp[1] & wp_d;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_cs   <= 2'h3;
            s_sck  <= 2'h0;
            s_si   <= 2'h0;
            s_hold <= 2'h3;
            s_wp   <= 2'h3;
            sck_d  <= 1'b0;
            cs_d   <= 1'b1;
            wp_d   <= 1'b1;
        end else begin
            s_cs   <= {s_cs[0], cs_n};
            s_sck  <= {s_sck[0], sck};
            s_si   <= {s_si[0], si};
            s_hold <= {s_hold[0], hold_n};
            s_wp   <= {s_wp[0], wp_n};
            sck_d  <= s_sck[1];
            cs_d   <= s_cs[1];
            wp_d   <= s_wp[1];
        end
    end

    // ************************************************************
    // array and registers
    // ************************************************************
    reg [7:0]           mem [0:DEPTH-1];
    reg [5:0]           state;
    reg [7:0]           shreg;
    reg [2:0]           bitcnt;
    reg [3:0]           addr_cnt;
    reg [ADDR_BITS-1:0] ptr;
    reg [7:0]           opcode;
    reg [7:0]           out_byte;
    reg                 wlatch;
    reg                 ppe;
    reg [1:0]           bp;
    reg                 wr_pending;
    reg                 sr_pending;
    reg [7:0]           sr_new;
    reg [31:0]          prog_cnt;
    reg                 prog_sr;
    reg [7:0]           prog_val;
    reg [ADDR_BITS-1:0] wr_addr;
    reg [ADDR_BITS-1:0] prog_addr;
    wire [7:0]          next_byte = {shreg[6:0], s_si[1]};
    wire                hw_lock   = ppe & ~s_wp[1]; // see RULE1 see RULE4

    // block protect decode, used only at page commit; write acceptance does not check it
    function prot;
        input [1:0]           b;
        input [ADDR_BITS-1:0] a;
        begin
            case (b)
                2'h1:    prot = (a[ADDR_BITS-1:ADDR_BITS-2] == 2'h3);
                2'h2:    prot = a[ADDR_BITS-1];
                2'h3:    prot = 1'b1;
                default: prot = 1'b0;
            endcase
        end
    endfunction

    // write data is staged through a small fifo and committed one byte per program
    // cycle; bytes beyond its depth are dropped, a deliberate trade for area
    wire [7:0] fifo_out;
    wire       fifo_valid;
    wire       fifo_in_ready;
    reg        fifo_push;
    reg        fifo_pop;
    reg        committing;

    seeprm_fifo #(
        .WIDTH (8),
        .DEPTH (PAGE_BUF),
        .AW    (2)
    ) u_wbuf (
        .sys_clk   (sys_clk),
        .reset     (reset),
        // flush once as select falls unless committing; a push lands the cycle after the 8th rise,
        // when shreg already holds the whole byte
        .flush     (sel & cs_d & ~committing),
        .in_data   (shreg),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // ************************************************************
    // serial protocol engine
    // ************************************************************
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state      <= ST_OPC;                      // see RULE16 see RULE17
            shreg      <= 8'h00;
            bitcnt     <= 3'h0;
            addr_cnt   <= 4'h0;
            ptr        <= {ADDR_BITS{1'b0}};
            opcode     <= 8'h00;
            out_byte   <= 8'h00;
            wlatch     <= 1'b0;                        // see RULE17
            ppe        <= 1'b0;
            bp         <= 2'h0;
            wr_pending <= 1'b0;
            sr_pending <= 1'b0;
            sr_new     <= 8'h00;
            prog_cnt   <= 32'h0;
            prog_sr    <= 1'b0;
            prog_val   <= 8'h00;
            wr_addr    <= {ADDR_BITS{1'b0}};
            prog_addr  <= {ADDR_BITS{1'b0}};
            busy       <= 1'b0;
            so         <= 1'b0;
            so_oe      <= 1'b0;
            status     <= 8'h00;
            fifo_push  <= 1'b0;
            fifo_pop   <= 1'b0;
            committing <= 1'b0;
        end else begin
            fifo_push <= 1'b0;
            fifo_pop  <= 1'b0;
            status    <= busy ? `SEEPRM_SR_BUSY_VAL
                              : {ppe, 3'h0, bp, wlatch, 1'b0};   // see RULE25
            // ---------- programming timer ----------
            if (busy) begin
                if (prog_cnt == PROG_CYC - 1) begin
                    prog_cnt <= 32'h0;
                    if (prog_sr) begin
                        ppe     <= prog_val[`SEEPRM_SR_PPE];       // see RULE3
                        bp      <= prog_val[`SEEPRM_SR_BPH:`SEEPRM_SR_BPL];
                        prog_sr <= 1'b0;
                        busy    <= 1'b0;
                        wlatch  <= 1'b0;                         // see RULE19
                    end else begin
                        if (!prot(bp, prog_addr)) begin
                            mem[prog_addr] <= fifo_out;
                        end
                        prog_addr <= prog_addr + 1'b1;
                        fifo_pop  <= 1'b1;
                        if (!fifo_valid || (fifo_valid && fifo_pop)) begin
                            busy       <= 1'b0;
                            committing <= 1'b0;
                            wlatch     <= 1'b0;                  // see RULE19
                        end
                    end
                end else begin
                    prog_cnt <= prog_cnt + 1'b1;
                end
                if (!prog_sr && committing && !fifo_valid && !fifo_pop) begin
                    busy       <= 1'b0;
                    committing <= 1'b0;
                    wlatch     <= 1'b0;
                end
            end
            // ---------- deselect ----------
            if (!sel) begin
                so_oe    <= 1'b0;                              // see RULE9 see RULE26
                state    <= ST_OPC;
                bitcnt   <= 3'h0;
                addr_cnt <= 4'h0;
            end else if (held) begin
                so_oe <= 1'b0;                                 // see RULE15
            end else if (state == ST_RDAT || state == ST_SRD) begin
                so_oe <= 1'b1;
            end
            if (wp_fall && sel && hw_lock) begin
                sr_pending <= 1'b0;                            // see RULE2
            end
            if (cs_rise) begin
                // only a whole number of data bytes starts programming
                if (sr_pending && bitcnt == 3'h0 && !hw_lock && !busy) begin
                    busy     <= 1'b1;                          // see RULE20
                    prog_sr  <= 1'b1;
                    prog_val <= sr_new;
                    prog_cnt <= 32'h0;
                end else if (wr_pending && bitcnt == 3'h0 && fifo_valid && !busy) begin
                    busy       <= 1'b1;                        // see RULE20
                    committing <= 1'b1;
                    prog_addr  <= wr_addr;
                    prog_cnt   <= 32'h0;
                end
                sr_pending <= 1'b0;
                wr_pending <= 1'b0;
                if (opcode == `SEEPRM_OP_WRITE_ENABLE_CMD && !busy && state == ST_IDLE) begin
                    wlatch <= 1'b1;
                end else if (opcode == `SEEPRM_OP_WRITE_DISABLE_CMD && !busy && state == ST_IDLE) begin
                    wlatch <= 1'b0;
                end
                opcode <= 8'h00;
            end
            // ---------- shifting ----------
            if (sck_rise) begin
                shreg  <= next_byte;
                bitcnt <= bitcnt + 1'b1;
                if (state == ST_OPC && bitcnt == `SEEPRM_BIT_LAST) begin
                    opcode <= next_byte;
                    case (next_byte)                           // see RULE23
                        `SEEPRM_OP_STATUS_RD: begin
                            state    <= ST_SRD;                // see RULE10 see RULE11
                            out_byte <= status;                // see RULE12
                        end
                        `SEEPRM_OP_READ: begin
                            state <= busy ? ST_IDLE : ST_ADDR; // see RULE21
                        end
                        `SEEPRM_OP_WRITE: begin
                            state <= (busy || !wlatch) ? ST_IDLE : ST_ADDR;
                        end
                        `SEEPRM_OP_STATUS_WR: begin
                            state <= (busy || !wlatch || hw_lock) ? ST_IDLE : ST_WDAT;
                        end
                        default: begin
                            state <= ST_IDLE;                  // see RULE22
                        end
                    endcase
                end else if (state == ST_ADDR && bitcnt == `SEEPRM_BIT_LAST) begin
                    addr_cnt <= addr_cnt + 1'b1;
                    if (addr_cnt == 4'h1) begin
                        // top received bit is ignored
                        ptr     <= {ptr[ADDR_BITS-9:0], next_byte}; // see RULE5 see RULE24
                        wr_addr <= {ptr[ADDR_BITS-9:0], next_byte};
                        if (opcode == `SEEPRM_OP_READ) begin
                            state    <= ST_RDAT;               // see RULE6
                            out_byte <= mem[{ptr[ADDR_BITS-9:0], next_byte}];
                        end else begin
                            state <= ST_WDAT;
                        end
                    end else begin
                        ptr <= {ptr[ADDR_BITS-9:0], next_byte};
                    end
                end else if (state == ST_WDAT && bitcnt == `SEEPRM_BIT_LAST) begin
                    if (opcode == `SEEPRM_OP_STATUS_WR) begin
                        sr_new     <= next_byte;
                        sr_pending <= ~hw_lock;                // see RULE1
                    end else begin
                        fifo_push  <= fifo_in_ready;
                        wr_pending <= 1'b1;
                    end
                end
            end
            if (sck_fall) begin
                if (state == ST_RDAT || state == ST_SRD) begin
                    so <= out_byte[7];
                    // reload only once bit 0 of the current byte is on the pin
                    if (bitcnt == `SEEPRM_BIT_LAST) begin
                        if (state == ST_RDAT) begin
                            out_byte <= {mem[ptr + 1'b1]};     // see RULE7
                            ptr      <= ptr + 1'b1;            // see RULE8
                        end else begin
                            out_byte <= status;
                        end
                    end else begin
                        out_byte <= {out_byte[6:0], 1'b0};
                    end
                end
            end
        end
    end
endmodule // seeprm_core

/* File: verification/seeprm_core_asserts.sv */
// checker for the seeprm_core serial pins and status image
// assumes it is bound to seeprm_core and sees its ports only
`timescale 1ns/100ps
module seeprm_core_asserts #(
    parameter PROG_CYC = 20,
    parameter PAGE_BUF = 4
) (
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic       si,
    input wire logic       hold_n,
    input wire logic       wp_n,
    input wire logic       so,
    input wire logic       so_oe,
    input wire logic       busy,
    input wire logic [7:0] status
);
    // ************************************************************
    // helper logic
    // ************************************************************
    logic [15:0] busy_cnt;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset)
            busy_cnt <= 16'h0000;
        else if (busy)
            busy_cnt <= busy_cnt + 16'h0001;
        else
            busy_cnt <= 16'h0000;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // pins pass a two-stage synchroniser, so four cycles of level settle
    sequence s_deselected; cs_n [*4]; endsequence
    sequence s_paused; !hold_n [*4]; endsequence
    // ************************************************************
    // properties
    // ************************************************************
    a_idle_release: assert property (s_deselected |-> !so_oe)
        else $error("serial out driven while deselected");
    a_pause_release: assert property (s_paused |-> !so_oe)
        else $error("serial out driven while paused");
    a_busy_image: assert property (busy && $past(busy) |-> status == 8'hff)
        else $error("status not all ones while programming");
    // one program period per staged byte, plus the pop and release cycles
    a_prog_max: assert property (busy |-> busy_cnt <= PAGE_BUF * PROG_CYC + 2)
        else $error("programming runs too long");
    a_prog_min: assert property ($fell(busy) |-> busy_cnt + 2 >= PROG_CYC)
        else $error("programming cut short");
    a_prog_start: assert property ($rose(busy) |-> cs_n && $past(cs_n))
        else $error("programming began while selected");
    a_status_gaps: assert property (!busy && !$past(busy) |-> status[6:4] == 3'h0)
        else $error("unused status bits not zero");
    a_latch_clear: assert property ($fell(busy) |-> ##[0:2] (status != 8'hff && !status[1]))
        else $error("write latch still set after programming");
    a_reset_state: assert property ($past(reset) |-> status == 8'h00 && !busy && !so_oe)
        else $error("wrong state after reset");
    a_so_on_fall: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
        else $error("serial out changed while clock high");
    c_prog: cover property ($rose(busy));
endmodule // seeprm_core_asserts

bind seeprm_core seeprm_core_asserts #(.PROG_CYC(PROG_CYC), .PAGE_BUF(PAGE_BUF)) u_chk (
    .sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy(busy), .status(status)
);

/* File: verification/seeprm_host.sv */
// spi host model: select, serial clock, serial in and pause, mode 0
// assumes so_line is already resolved by the bench when not driven
`timescale 1ns/100ps
module seeprm_host (
    output reg  cs_n,
    output reg  sck,
    output reg  si,
    output reg  hold_n,
    input  wire so_line
);
    reg [7:0] rx_byte;
    event     got;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        rx_byte = 8'h00;
    end
    // clock stands low outside frames
    task sel;
        #62.5 cs_n = 1'b0;
        #62.5;
    endtask
    task desel;
        #62.5 cs_n = 1'b1;
        #250;
    endtask
    task xfer(input [7:0] tx, input chk);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            si = tx[i];
            #62.5 sck = 1'b1;
            rx_byte = {rx_byte[6:0], so_line};
            #62.5 sck = 1'b0;
        end
        if (chk)
            -> got;
    endtask
    // select stays low and the clock low for the whole pause
    task hold_on;
        integer i;
        #20 hold_n = 1'b0;
        for (i = 0; i < 6; i = i + 1) begin
            #60 si = ~si;
        end
    endtask
    task hold_off;
        #20 hold_n = 1'b1;
        #62.5;
    endtask
endmodule // seeprm_host

/* File: verification/seeprm_core_tb.sv */
// self-checking bench for seeprm_core with a behavioural spi host
// assumes programming time shortened through PROG_CYC
`timescale 1ns/100ps
`include "seeprm_map.vh"
module seeprm_core_tb;
    localparam PROG_CYC = 1000;
    reg         sys_clk = 1'b0;
    reg         reset = 1'b1;
    reg         wp_n = 1'b1;
    reg         so_last = 1'b0;
    wire        cs_n, sck, si, hold_n, so, so_oe, busy, so_line;
    wire [7:0]  status;
    reg  [7:0]  expq[$];
    reg  [31:0] seed = 32'h3b98b4f4;
    reg  [7:0]  da, db, dc;
    integer     fails = 0;
    integer     samples_checked = 0;
    always #4 sys_clk = ~sys_clk;
    // a released line shows the inverse of its last value, never a lucky match
    always @(posedge sys_clk) if (so_oe) so_last <= so;
    assign so_line = so_oe ? so : ~so_last;
    seeprm_core #(.PROG_CYC(PROG_CYC)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy(busy), .status(status)
    );
    seeprm_host u_host (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so_line(so_line));
    // ************************************************************
    // helpers
    // ************************************************************
    function [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction
    task check(input [7:0] got, input [7:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task check_low(input got);
        check({7'h00, got}, 8'h00);
    endtask
    always @(u_host.got) check(u_host.rx_byte, (expq.size() > 0) ? expq.pop_front() : 8'hxx);
    task stop_test;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task drive_wp(input v);
        @(posedge sys_clk) #1.1 wp_n = v;
    endtask
    task cmd1(input [7:0] op);
        u_host.sel;
        u_host.xfer(op, 1'b0);
        u_host.desel;
    endtask
    task status_read_cmd(input [7:0] exp);
        u_host.sel;
        u_host.xfer(`SEEPRM_OP_STATUS_RD, 1'b0);
        expq.push_back(exp);
        u_host.xfer(8'h00, 1'b1);
        u_host.desel;
    endtask
    task status_write_cmd(input [7:0] v, input drop);
        cmd1(`SEEPRM_OP_WRITE_ENABLE_CMD);
        u_host.sel;
        u_host.xfer(`SEEPRM_OP_STATUS_WR, 1'b0);
        u_host.xfer(v, 1'b0);
        if (drop) begin
            // low pulse only: the pin is high again at deselect
            drive_wp(1'b0);
            repeat (4) @(posedge sys_clk);
            drive_wp(1'b1);
        end
        u_host.desel;
    endtask
    task wr(input [15:0] a, input [7:0] d0, input [7:0] d1, input two);
        cmd1(`SEEPRM_OP_WRITE_ENABLE_CMD);
        u_host.sel;
        u_host.xfer(`SEEPRM_OP_WRITE, 1'b0);
        u_host.xfer(a[15:8], 1'b0);
        u_host.xfer(a[7:0], 1'b0);
        u_host.xfer(d0, 1'b0);
        if (two)
            u_host.xfer(d1, 1'b0);
        u_host.desel;
    endtask
    task no_drive(input [7:0] op);
        u_host.sel;
        u_host.xfer(op, 1'b0);
        repeat (3) u_host.xfer(8'h00, 1'b0);
        check_low(so_oe);
        u_host.desel;
    endtask
    task wait_idle;
        integer n;
        n = 0;
        while (busy !== 1'b0 && n < 4 * PROG_CYC) begin
            @(posedge sys_clk) #1.1;
            n = n + 1;
        end
        check_low(busy);
    endtask
    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        #400000;
        fails = fails + 1;
        stop_test;
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        // off-grid skew keeps every host change away from a sys_clk edge
        #1.1 reset = 1'b0;
        check(status, 8'h00);
        check_low(so_oe);
        seed = xs(seed);
        da = seed[7:0];
        db = seed[15:8];
        dc = seed[23:16];
        status_read_cmd(8'h00);
        cmd1(`SEEPRM_OP_WRITE_ENABLE_CMD);
        status_read_cmd(8'h02);
        cmd1(`SEEPRM_OP_WRITE_DISABLE_CMD);
        status_read_cmd(8'h00);
        $display("test power_up done");
        wr(16'h7fff, da, 8'h00, 1'b0);
        status_read_cmd(8'hff);
        wait_idle;
        status_read_cmd(8'h00);
        wr(16'h8000, db, dc, 1'b1);
        no_drive(`SEEPRM_OP_READ);
        wait_idle;
        no_drive(8'ha5);
        u_host.sel;
        u_host.xfer(`SEEPRM_OP_READ, 1'b0);
        u_host.xfer(8'h7f, 1'b0);
        u_host.xfer(8'hff, 1'b0);
        expq.push_back(da);
        u_host.xfer(8'h00, 1'b1);
        u_host.hold_on;
        check_low(so_oe);
        u_host.hold_off;
        expq.push_back(db);
        u_host.xfer(8'h00, 1'b1);
        expq.push_back(dc);
        u_host.xfer(8'h00, 1'b1);
        u_host.desel;
        check_low(so_oe);
        $display("test array_read done");
        drive_wp(1'b0);
        status_write_cmd(8'h0c, 1'b0);
        wait_idle;
        status_read_cmd(8'h0c);
        drive_wp(1'b1);
        status_write_cmd(8'h8c, 1'b0);
        wait_idle;
        status_read_cmd(8'h8c);
        drive_wp(1'b0);
        status_write_cmd(8'h00, 1'b0);
        check_low(busy);
        cmd1(`SEEPRM_OP_WRITE_DISABLE_CMD);
        status_read_cmd(8'h8c);
        drive_wp(1'b1);
        status_write_cmd(8'h00, 1'b1);
        cmd1(`SEEPRM_OP_WRITE_DISABLE_CMD);
        status_read_cmd(8'h8c);
        drive_wp(1'b1);
        status_write_cmd(8'h00, 1'b0);
        drive_wp(1'b0);
        wait_idle;
        status_read_cmd(8'h00);
        $display("test status_protect done");
        stop_test;
    end
endmodule // seeprm_core_tb
